// ===== hw/mpl_link_top.sv
// Purpose: device end of the single-wire Manchester programming link
// Assumes: lock bits and memory come from outside; mem_rdata valid one cycle after mem_rd
// Notes: the output pin carries the link while overvoltage entry is allowed or once the stay flag is set
`timescale 1ns/1ps
module mpl_link_top #(
    parameter logic [15:0] HALF_MAX_CYC = mpl_pkg::HALF_MAX_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic program_pin_i,
    output logic program_pin_o,
    output logic program_pin_oe,
    input wire logic analog_output_pin_i,
    output logic analog_output_pin_o,
    output logic analog_output_pin_oe,
    input wire logic supply_overvoltage_entry,
    input wire logic output_pin_program_pin_disable,
    input wire logic write_lock_bit,
    output logic [mpl_pkg::ADDR_W-1:0] mem_addr,
    output logic [mpl_pkg::DATA_W-1:0] mem_wdata,
    output logic mem_we_ee,
    output logic mem_we_vol,
    output logic mem_rd,
    input wire logic [mpl_pkg::DATA_W-1:0] mem_rdata,
    output logic analog_output_en,
    output logic magnetic_resp_en,
    output logic stay_in_link_flag,
    output logic session_open,
    output logic ecc_fatal
);
    import mpl_pkg::*;

    // Two-stage synchronisers for pins and the supply comparator
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {supply_overvoltage_entry, analog_output_pin_i, program_pin_i};
            sync2_r <= sync1_r;
        end
    end
    wire program_pin_s = sync2_r[0];
    wire aout_s = sync2_r[1];
    wire ovd_s = sync2_r[2];

    mpl_link_st_t st_r;
    logic stay_r;
    logic refused_r;
    logic open_r;
    logic fatal_r;
    logic wlock_r;
    logic wlock_cap_r;
    logic use_aout_q_r;

    wire aout_entry = ovd_s & ~output_pin_program_pin_disable & ~refused_r;
    wire use_aout = stay_r | aout_entry;
    wire rx_line = (st_r != ST_RX) ? 1'b0 : (use_aout ? aout_s : program_pin_s);

    logic bit_stb;
    logic bit_val;
    logic frame_end;
    logic [15:0] half_cyc;
    mpl_manch_rx #(.HALF_MAX(HALF_MAX_CYC)) u_rx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .line_i(rx_line),
        .bit_stb(bit_stb),
        .bit_val(bit_val),
        .frame_end(frame_end),
        .half_cyc(half_cyc)
    );

    // Frame collection, MSB first
    logic [BITS_W-1:0] bits_r;
    logic [5:0] bcnt_r;
    logic ovf_r;
    always_ff @(posedge core_clk) begin
        if (!rst_n || frame_end) begin
            bits_r <= '0;
            bcnt_r <= '0;
            ovf_r <= 1'b0;
        end else if (bit_stb) begin
            bits_r <= {bits_r[BITS_W-2:0], bit_val};
            if (bcnt_r == FRM_WR_BITS) ovf_r <= 1'b1;
            else bcnt_r <= 6'(bcnt_r + 6'h01);
        end
    end

    function automatic logic [2:0] crc_calc(input logic [40:0] v, input logic [5:0] n);
        logic [2:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = 40; i >= 0; i--) begin
            if (i < int'(n)) begin
                fb = c[2] ^ v[i];
                c = {c[1], c[0] ^ fb, fb};
            end
        end
        return c;
    endfunction

    wire len_wr = bcnt_r == FRM_WR_BITS;
    wire len_rd = bcnt_r == FRM_RD_BITS;
    wire len_rs = bcnt_r == FRM_RS_BITS;
    wire [5:0] body_n = 6'(bcnt_r - 6'(SYNC_BITS + CRC_W));
    wire [5:0] rw_pos = 6'(bcnt_r - 6'(SYNC_BITS + 1));
    wire [1:0] sync_w = 2'(bits_r >> (bcnt_r - 6'(SYNC_BITS)));
    wire rw_w = bits_r[rw_pos];
    wire crc_ok = crc_calc(41'(bits_r >> CRC_W), body_n) == bits_r[CRC_W-1:0];
    wire [ADDR_W-1:0] f_addr =
        len_wr ? bits_r[WR_ADDR_LSB +: ADDR_W] : bits_r[RD_ADDR_LSB +: ADDR_W];
    wire [DATA_W-1:0] f_data = bits_r[WR_DATA_LSB +: DATA_W];
    wire frm_ok = frame_end && st_r == ST_RX && !ovf_r && crc_ok && sync_w == 2'b00;
    wire is_wr = frm_ok && len_wr && !rw_w;
    wire is_rd = frm_ok && (len_rd || len_rs) && rw_w;
    wire key_hit = is_wr && f_addr == KEY_ADDR;
    wire key_ok = key_hit && f_data[DATA_W-1:1] == KEY_CODE[DATA_W-1:1];
    wire cmd_wr = is_wr && !key_hit && open_r;
    wire cmd_rd = is_rd && open_r;
    wire to_vol = f_addr >= VOL_ADDR_BASE;

    // Session, key and lock state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stay_r <= 1'b0;
            refused_r <= 1'b0;
            open_r <= 1'b0;
            use_aout_q_r <= 1'b0;
        end else begin
            use_aout_q_r <= use_aout;
            if (key_ok) begin
                open_r <= 1'b1;
            end else if (use_aout != use_aout_q_r) begin
                open_r <= 1'b0;
            end
            if (key_ok && f_data[KEY_FLAG_BIT]) stay_r <= 1'b1;
            if (key_hit && !key_ok && use_aout && !stay_r) refused_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wlock_cap_r <= 1'b0;
            wlock_r <= 1'b0;
        end else if (!wlock_cap_r) begin
            wlock_cap_r <= 1'b1;
            wlock_r <= write_lock_bit;
        end
    end

    logic [5:0] enc_ecc;
    logic [PAY_W-1:0] dec_data;
    logic [1:0] dec_status;
    mpl_hamming u_ecc (
        .enc_data(f_data[PAY_W-1:0]),
        .enc_ecc(enc_ecc),
        .dec_word(mem_rdata),
        .dec_data(dec_data),
        .dec_status(dec_status)
    );

    // Memory port
    logic [ADDR_W-1:0] last_addr_r;
    wire [ADDR_W-1:0] rd_addr = len_rs ? last_addr_r : f_addr;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mem_addr <= '0;
            mem_wdata <= '0;
            mem_we_ee <= 1'b0;
            mem_we_vol <= 1'b0;
            mem_rd <= 1'b0;
            last_addr_r <= '0;
        end else begin
            mem_we_ee <= 1'b0;
            mem_we_vol <= 1'b0;
            mem_rd <= 1'b0;
            if (cmd_wr) begin
                mem_addr <= f_addr;
                last_addr_r <= f_addr;
                mem_wdata <= {enc_ecc, f_data[PAY_W-1:0]};
                mem_we_vol <= to_vol;
                mem_we_ee <= !to_vol && !wlock_r;
            end else if (cmd_rd) begin
                mem_addr <= rd_addr;
                last_addr_r <= rd_addr;
                mem_rd <= 1'b1;
            end
        end
    end

    // Reply sequencing and drive
    logic [REPLY_BITS-1:0] tx_sh_r;
    logic [5:0] tbit_r;
    logic [15:0] tcnt_r;
    logic tphase_r;
    logic tx_lvl_r;
    logic tx_oe_r;
    logic tx_aout_r;
    logic fetch_wait_r;
    wire [15:0] half_end = 16'(half_cyc - CNT_ONE);
    wire [15:0] turn_end = 16'((half_cyc * TURN_HALVES) - 1);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= ST_RX;
            tx_sh_r <= '0;
            tbit_r <= '0;
            tcnt_r <= '0;
            tphase_r <= 1'b0;
            tx_lvl_r <= 1'b0;
            tx_oe_r <= 1'b0;
            tx_aout_r <= 1'b0;
            fatal_r <= 1'b0;
            fetch_wait_r <= 1'b0;
        end else begin
            tcnt_r <= 16'(tcnt_r + CNT_ONE);
            unique case (st_r)
                ST_RX: if (cmd_rd) begin
                    st_r <= ST_FETCH;
                    tx_aout_r <= use_aout;
                    fetch_wait_r <= 1'b1;
                end
                // Memory answers one cycle after the read strobe
                ST_FETCH: if (fetch_wait_r) begin
                    fetch_wait_r <= 1'b0;
                end else begin
                    tx_sh_r <= {{SYNC_BITS{1'b0}}, REPLY_PAD, dec_status, dec_data};
                    if (dec_status == ECC_BAD) fatal_r <= 1'b1;
                    tcnt_r <= '0;
                    st_r <= ST_TURN;
                end
                ST_TURN: if (tcnt_r >= turn_end) begin
                    st_r <= ST_TX;
                    tcnt_r <= '0;
                    tbit_r <= '0;
                    tphase_r <= 1'b0;
                    tx_lvl_r <= tx_sh_r[REPLY_BITS-1];
                    tx_oe_r <= 1'b1;
                end
                ST_TX: if (tcnt_r >= half_end) begin
                    tcnt_r <= '0;
                    if (!tphase_r) begin
                        tphase_r <= 1'b1;
                        tx_lvl_r <= ~tx_sh_r[REPLY_BITS-1];
                    end else if (tbit_r == 6'(REPLY_BITS - 6'h01)) begin
                        tx_oe_r <= 1'b0;
                        tx_lvl_r <= 1'b0;
                        st_r <= ST_RX;
                    end else begin
                        tphase_r <= 1'b0;
                        tbit_r <= 6'(tbit_r + 6'h01);
                        tx_sh_r <= {tx_sh_r[REPLY_BITS-2:0], 1'b0};
                        tx_lvl_r <= tx_sh_r[REPLY_BITS-2];
                    end
                end
                default: st_r <= ST_RX;
            endcase
        end
    end

    assign program_pin_o = tx_lvl_r & ~tx_aout_r;
    assign program_pin_oe = tx_oe_r & ~tx_aout_r;
    assign analog_output_pin_o = tx_lvl_r & tx_aout_r;
    assign analog_output_pin_oe = tx_oe_r & tx_aout_r;
    assign analog_output_en = ~stay_r & ~fatal_r & ~(use_aout & open_r);
    assign magnetic_resp_en = ~fatal_r;
    assign stay_in_link_flag = stay_r;
    assign session_open = open_r;
    assign ecc_fatal = fatal_r;
endmodule

// ===== hw/mpl_pkg.sv
// Purpose: shared constants and types of the Manchester programming link
// Assumes: core clock of 10 MHz
// Notes: bit positions count from the last received bit (bit 0 = last CRC bit)
package mpl_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_BIT_MIN_NS = 7500;
    localparam int T_BIT_MAX_NS = 1000000;
    // Shortest half bit rounds up, longest rounds down
    localparam logic [15:0] HALF_MIN_CYC =
        16'((T_BIT_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] HALF_MAX_CYC_DEF = 16'((T_BIT_MAX_NS / 2) / CLK_PERIOD_NS);
    localparam logic [15:0] CNT_SAT = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam int TURN_HALVES = 2;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int PAY_W = 26;
    localparam int ECC_W = 6;
    localparam int CRC_W = 3;
    localparam int SYNC_BITS = 2;
    localparam int BITS_W = 44;
    localparam logic [2:0] CRC_INIT = 3'h7;
    localparam logic [5:0] FRM_WR_BITS = 6'h2C;
    localparam logic [5:0] FRM_RD_BITS = 6'h0C;
    localparam logic [5:0] FRM_RS_BITS = 6'h06;
    localparam logic [5:0] REPLY_BITS = 6'h22;
    localparam int WR_ADDR_LSB = 35;
    localparam int WR_DATA_LSB = 3;
    localparam int RD_ADDR_LSB = 3;
    localparam int KEY_FLAG_BIT = 0;

    localparam logic [5:0] KEY_ADDR = 6'h31;
    localparam logic [31:0] KEY_CODE = 32'h2C413736;
    // Addresses at or above this base are volatile registers
    localparam logic [5:0] VOL_ADDR_BASE = 6'h20;

    localparam logic [1:0] ECC_OK = 2'h0;
    localparam logic [1:0] ECC_FIX = 2'h1;
    localparam logic [1:0] ECC_BAD = 2'h2;
    localparam logic [3:0] REPLY_PAD = 4'h0;

    typedef enum logic [1:0] {RX_IDLE, RX_MEAS, RX_RUN} mpl_rx_st_t;
    typedef enum logic [1:0] {ST_RX, ST_FETCH, ST_TURN, ST_TX} mpl_link_st_t;
endpackage

// ===== hw/mpl_manch_rx.sv
// Purpose: Manchester bit recovery from edge timing
// Assumes: line_i already synchronised; line idles low before a frame
// Notes: half bit is measured on the two sync bits; 3 silent half bits end a frame
`timescale 1ns/1ps
module mpl_manch_rx #(
    parameter logic [15:0] HALF_MAX = mpl_pkg::HALF_MAX_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic line_i,
    output logic bit_stb,
    output logic bit_val,
    output logic frame_end,
    output logic [15:0] half_cyc
);
    import mpl_pkg::*;

    mpl_rx_st_t st_r;
    logic line_q_r;
    logic [15:0] cnt_r;
    logic [15:0] half_r;
    wire edge_w = line_i ^ line_q_r;
    wire [15:0] late_w = 16'(half_r + {1'b0, half_r[15:1]});
    wire [15:0] tmo_w = 16'(half_r + {half_r[14:0], 1'b0});

    assign half_cyc = half_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= RX_IDLE;
            line_q_r <= 1'b0;
            cnt_r <= '0;
            half_r <= '0;
            bit_stb <= 1'b0;
            bit_val <= 1'b0;
            frame_end <= 1'b0;
        end else begin
            line_q_r <= line_i;
            bit_stb <= 1'b0;
            frame_end <= 1'b0;
            cnt_r <= (cnt_r == CNT_SAT) ? cnt_r : 16'(cnt_r + CNT_ONE);
            unique case (st_r)
                RX_IDLE: if (edge_w && line_i) begin
                    st_r <= RX_MEAS;
                    cnt_r <= '0;
                    bit_stb <= 1'b1;
                    bit_val <= 1'b0;
                end
                // Aborted starts also end the frame so stray strobes never linger
                RX_MEAS: if (edge_w) begin
                    if (cnt_r < HALF_MIN_CYC) begin
                        frame_end <= 1'b1;
                        st_r <= RX_IDLE;
                    end else begin
                        half_r <= 16'(cnt_r + CNT_ONE);
                        st_r <= RX_RUN;
                    end
                end else if (cnt_r > HALF_MAX) begin
                    frame_end <= 1'b1;
                    st_r <= RX_IDLE;
                end
                RX_RUN: if (edge_w && cnt_r >= late_w) begin
                    bit_stb <= 1'b1;
                    bit_val <= ~line_i;
                    cnt_r <= '0;
                end else if (cnt_r >= tmo_w) begin
                    frame_end <= 1'b1;
                    st_r <= RX_IDLE;
                end
                default: st_r <= RX_IDLE;
            endcase
        end
    end
endmodule

// ===== hw/mpl_hamming.sv
// Purpose: Hamming SEC-DED encoder and checker for 26-bit words
// Assumes: check bits sit at word bits 31:26, overall parity on top
// Notes: purely combinational
`timescale 1ns/1ps
module mpl_hamming (
    input wire logic [25:0] enc_data,
    output logic [5:0] enc_ecc,
    input wire logic [31:0] dec_word,
    output logic [25:0] dec_data,
    output logic [1:0] dec_status
);
    import mpl_pkg::*;

    // Data bits go to code positions that are not powers of two
    function automatic logic [31:0] place(input logic [25:0] d);
        logic [31:0] v;
        int j;
        v = '0;
        j = 0;
        for (int i = 1; i < 32; i++) begin
            if ((i & (i - 1)) != 0) begin
                v[i] = d[j];
                j++;
            end
        end
        return v;
    endfunction

    function automatic logic [4:0] synd(input logic [31:0] v);
        logic [4:0] s;
        s = '0;
        for (int i = 1; i < 32; i++) begin
            if (v[i]) s = s ^ 5'(i);
        end
        return s;
    endfunction

    wire [31:0] enc_cw = place(enc_data);
    wire [4:0] enc_p = synd(enc_cw);
    assign enc_ecc = {(^enc_cw) ^ (^enc_p), enc_p};

    always_comb begin
        logic [31:0] v;
        logic [4:0] s;
        logic par;
        int j;
        s = '0;
        par = 1'b0;
        j = 0;
        v = place(dec_word[PAY_W-1:0]);
        for (int k = 0; k < 5; k++) v[1 << k] = dec_word[PAY_W + k];
        s = synd(v);
        par = (^v) ^ dec_word[DATA_W-1];
        if (par && s != 5'h00) v[s] = ~v[s];
        if (!par && s == 5'h00) dec_status = ECC_OK;
        else if (par) dec_status = ECC_FIX;
        else dec_status = ECC_BAD;
        dec_data = '0;
        j = 0;
        for (int i = 1; i < 32; i++) begin
            if ((i & (i - 1)) != 0) begin
                dec_data[j] = v[i];
                j++;
            end
        end
    end
endmodule

// ===== tb/mpl_link_checker.sv
// Purpose: port-level checker for the Manchester programming link
// Assumes: write_lock_bit only changes while reset is held
// Notes: bound into mpl_link_top
`timescale 1ns/1ps
module mpl_link_checker #(
    parameter logic [15:0] HALF_MAX_CYC = mpl_pkg::HALF_MAX_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic program_pin_o,
    input wire logic program_pin_oe,
    input wire logic analog_output_pin_oe,
    input wire logic output_pin_program_pin_disable,
    input wire logic write_lock_bit,
    input wire logic [mpl_pkg::ADDR_W-1:0] mem_addr,
    input wire logic mem_we_ee,
    input wire logic mem_we_vol,
    input wire logic mem_rd,
    input wire logic analog_output_en,
    input wire logic magnetic_resp_en,
    input wire logic stay_in_link_flag,
    input wire logic ecc_fatal
);
    import mpl_pkg::*;
    // Turnaround is two half bits, far below this bound
    localparam int RD_TO_OE = 1000;
    logic any_oe;
    assign any_oe = program_pin_oe | analog_output_pin_oe;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    a_strobe_onehot: assert property ($onehot0({mem_we_ee, mem_we_vol, mem_rd}))
        else $error("two memory strobes at once");
    a_ee_addr_low: assert property (mem_we_ee |-> mem_addr < VOL_ADDR_BASE)
        else $error("eeprom write above base");
    a_vol_addr_high: assert property (mem_we_vol |-> mem_addr >= VOL_ADDR_BASE)
        else $error("volatile write below base");
    a_write_no_reply: assert property ((mem_we_ee || mem_we_vol) |=> !any_oe [*8])
        else $error("line driven after a write");
    a_read_gets_reply: assert property (mem_rd |-> ##[1:RD_TO_OE] any_oe)
        else $error("no reply after read");
    a_reply_sync_low: assert property ($rose(program_pin_oe) |-> !program_pin_o)
        else $error("reply starts high");
    a_fatal_floats: assert property (
        ecc_fatal |-> !magnetic_resp_en && !analog_output_en)
        else $error("output live after fatal error");
    a_stay_holds: assert property (
        stay_in_link_flag |-> !analog_output_en ##1 stay_in_link_flag)
        else $error("stay flag lost or output enabled");
    a_lock_no_out: assert property (
        output_pin_program_pin_disable && !stay_in_link_flag |-> !analog_output_pin_oe)
        else $error("output pin driven while locked");
    a_wlock_no_ee: assert property (write_lock_bit |-> !mem_we_ee)
        else $error("eeprom write under write lock");
endmodule

bind mpl_link_top mpl_link_checker #(.HALF_MAX_CYC(HALF_MAX_CYC)) u_chk (
    .core_clk, .rst_n, .program_pin_o, .program_pin_oe, .analog_output_pin_oe,
    .output_pin_program_pin_disable, .write_lock_bit, .mem_addr, .mem_we_ee, .mem_we_vol,
    .mem_rd, .analog_output_en, .magnetic_resp_en, .stay_in_link_flag, .ecc_fatal
);

// ===== tb/mpl_ctrl_model.sv
// Purpose: programming controller on the far side of the link
// Assumes: tasks are entered just after a rising clock edge
// Notes: the bench resolves the line while nobody drives it
`timescale 1ns/1ps
module mpl_ctrl_model (
    input wire logic core_clk,
    input wire logic line,
    input wire logic dev_oe,
    output logic drv_en,
    output logic drv_lvl
);
    int half = 40;
    initial begin
        drv_en = 1'b1;
        drv_lvl = 1'b0;
    end
    task automatic send(input logic [43:0] f, input int n, input logic rd,
        output logic [33:0] r, output logic ok);
        logic a;
        int t;
        r = '0;
        ok = 1'b0;
        drv_lvl <= 1'b0;
        repeat (2 * half) @(posedge core_clk);
        for (int i = n - 1; i >= 0; i--) begin
            drv_lvl <= f[i];
            repeat (half) @(posedge core_clk);
            drv_lvl <= ~f[i];
            repeat (half) @(posedge core_clk);
        end
        drv_lvl <= 1'b0;
        repeat (4 * half) @(posedge core_clk);
        if (rd) begin
            drv_en <= 1'b0;
            for (t = 0; t < 2000 && !dev_oe; t++) @(posedge core_clk);
            ok = dev_oe;
            for (int i = 33; i >= 0 && ok; i--) begin
                repeat (half / 2) @(posedge core_clk);
                a = line;
                repeat (half) @(posedge core_clk);
                r[i] = a;
                ok = (line !== a);
                repeat (half - half / 2) @(posedge core_clk);
            end
            for (t = 0; t < 4000 && dev_oe; t++) @(posedge core_clk);
            drv_en <= 1'b1;
        end
        repeat (740) @(posedge core_clk);
    endtask
endmodule

// ===== tb/manchester_program_pin_link_tb.sv
// Purpose: self-checking bench for the Manchester programming link
// Assumes: half bit of 40 cycles, design half limit of 200
// Notes: memory behind the link lives here, with bit-flip injection
`timescale 1ns/1ps
module manchester_program_pin_link_tb;
    import mpl_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic use_out = 1'b0;
    logic ov_entry = 1'b0;
    logic lock_out = 1'b0;
    logic wlock = 1'b0;
    logic pp_last = 1'b0;
    logic op_last = 1'b0;
    logic [31:0] flip = '0;
    logic [31:0] rdata_q = '0;
    logic [31:0] mem [64];
    logic pp_o, pp_oe, op_o, op_oe, drv_en, drv_lvl, pp_w, op_w, rep_ok;
    logic mem_we_ee, mem_we_vol, mem_rd, aen, men, stay, sess, fatal;
    logic [5:0] mem_addr;
    logic [31:0] mem_wdata, mem_rdata;
    logic [33:0] rep;
    int num_errors = 0;
    int n_tests = 0;
    int n_ee = 0;
    int n_vol = 0;
    int cyc = 0;
    int seed = 99;

    always #50 core_clk = ~core_clk;
    // Undriven lines toggle so a stale level is never mistaken for data
    assign pp_w = pp_oe ? pp_o : (!use_out && drv_en) ? drv_lvl : ~pp_last;
    assign op_w = op_oe ? op_o : (use_out && drv_en) ? drv_lvl : ~op_last;
    // Read data follows the strobe by one cycle, like a registered memory
    assign mem_rdata = rdata_q ^ flip;
    always @(posedge core_clk) begin
        pp_last <= pp_w;
        op_last <= op_w;
        cyc <= cyc + 1;
        n_ee <= n_ee + int'(mem_we_ee);
        n_vol <= n_vol + int'(mem_we_vol);
        if (mem_we_ee | mem_we_vol) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_rd) begin
            rdata_q <= mem[mem_addr];
        end
        if (cyc == 99000) begin
            num_errors++;
            results();
        end
    end

    mpl_link_top #(.HALF_MAX_CYC(16'h00C8)) DUT (
        .core_clk, .rst_n, .program_pin_i(pp_w), .program_pin_o(pp_o),
        .program_pin_oe(pp_oe), .analog_output_pin_i(op_w), .analog_output_pin_o(op_o),
        .analog_output_pin_oe(op_oe), .supply_overvoltage_entry(ov_entry),
        .output_pin_program_pin_disable(lock_out), .write_lock_bit(wlock), .mem_addr, .mem_wdata,
        .mem_we_ee, .mem_we_vol, .mem_rd, .mem_rdata, .analog_output_en(aen),
        .magnetic_resp_en(men), .stay_in_link_flag(stay), .session_open(sess),
        .ecc_fatal(fatal)
    );
    mpl_ctrl_model u_ctrl (
        .core_clk, .line(use_out ? op_w : pp_w), .dev_oe(use_out ? op_oe : pp_oe),
        .drv_en, .drv_lvl
    );

    function automatic logic [2:0] crc3(input logic [38:0] b, input int n);
        logic [2:0] c;
        logic fb;
        c = 3'h7;
        for (int i = n - 1; i >= 0; i--) begin
            fb = c[2] ^ b[i];
            c = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction
    function automatic logic [30:0] exp_rep(input logic [1:0] st, input logic [31:0] d);
        return {1'b1, 2'b00, st, d[25:0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished at %0t", s, $time);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic boot(input logic wl, input logic lk, input logic ov, input logic uo);
        rst_n <= 1'b0;
        wlock <= wl;
        lock_out <= lk;
        ov_entry <= ov;
        use_out <= uo;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic xfer(input logic rw, input logic [5:0] a, input logic [31:0] d,
        input int kind, input logic [2:0] bad);
        logic [43:0] f;
        int n;
        if (kind == 0) begin
            f = {2'b00, rw, a, d, crc3({rw, a, d}, 39) ^ bad};
            n = 44;
        end else if (kind == 1) begin
            f = {32'h0, 2'b00, rw, a, crc3({32'h0, rw, a}, 7) ^ bad};
            n = 12;
        end else begin
            f = {38'h0, 2'b00, rw, crc3({38'h0, rw}, 1) ^ bad};
            n = 6;
        end
        u_ctrl.send(f, n, rw, rep, rep_ok);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic acc);
        int e0;
        int v0;
        e0 = n_ee;
        v0 = n_vol;
        xfer(1'b0, a, d, 0, 3'h0);
        check(32'(n_ee - e0), 32'(acc && a < VOL_ADDR_BASE));
        check(32'(n_vol - v0), 32'(acc && a >= VOL_ADDR_BASE));
        if (acc) begin
            check({mem_addr, mem_wdata[25:0]}, {a, d[25:0]});
        end
    endtask
    task automatic rd(input logic [5:0] a, input int kind, input logic [1:0] st,
        input logic [31:0] d);
        xfer(1'b1, a, 32'h0, kind, 3'h0);
        check(32'({rep_ok, rep[33:32], rep[27:0]}), 32'(exp_rep(st, d)));
        done("read");
    endtask

    initial begin
        logic [5:0] a;
        logic [31:0] d;
        logic [31:0] w0;
        boot(1'b0, 1'b0, 1'b0, 1'b0);
        check(32'({sess, stay, aen, men, fatal}), 32'h6);
        wr(6'h21, 32'h0000_1234, 1'b0);
        xfer(1'b0, KEY_ADDR, KEY_CODE, 0, 3'h5);
        check(32'(sess), 32'h0);
        xfer(1'b0, KEY_ADDR, KEY_CODE, 0, 3'h0);
        check(32'({sess, stay, aen}), 32'h5);
        done("key");
        wr(6'h1F, $random(seed), 1'b1);
        wr(6'h20, $random(seed), 1'b1);
        a = 6'($random(seed)) & 6'h2F;
        d = $random(seed);
        wr(a, d, 1'b1);
        w0 = mem_wdata;
        wr(a, {~d[31:26], d[25:0]}, 1'b1);
        check(mem_wdata, w0);
        done("writes");
        rd(a, 1, ECC_OK, d);
        flip <= 32'h1 << ($unsigned($random(seed)) % 26);
        rd(a, 2, ECC_FIX, d);
        flip <= 32'h0010_0008;
        xfer(1'b1, a, 32'h0, 2, 3'h0);
        check(32'({rep_ok, rep[27:26], fatal, men, aen}), {26'h0, 1'b1, ECC_BAD, 3'b100});
        flip <= '0;
        done("ecc");
        boot(1'b1, 1'b0, 1'b0, 1'b0);
        xfer(1'b0, KEY_ADDR, KEY_CODE, 0, 3'h0);
        wr(6'h05, $random(seed), 1'b0);
        wr(6'h2A, $random(seed), 1'b1);
        done("write lock");
        boot(1'b0, 1'b1, 1'b1, 1'b1);
        xfer(1'b0, KEY_ADDR, KEY_CODE, 0, 3'h0);
        check(32'(sess), 32'h0);
        boot(1'b0, 1'b0, 1'b1, 1'b1);
        xfer(1'b0, KEY_ADDR, KEY_CODE ^ 32'h0000_0100, 0, 3'h0);
        xfer(1'b0, KEY_ADDR, KEY_CODE, 0, 3'h0);
        check(32'({sess, aen}), 32'h1);
        boot(1'b0, 1'b0, 1'b1, 1'b1);
        xfer(1'b0, KEY_ADDR, KEY_CODE | 32'h1, 0, 3'h0);
        check(32'({sess, stay, aen}), 32'h6);
        ov_entry <= 1'b0;
        d = $random(seed);
        wr(6'h22, d, 1'b1);
        rd(6'h22, 1, ECC_OK, d);
        done("output pin");
        results();
    end
endmodule
